// *** hdl/ccd_dec_if.sv ***
`default_nettype none
interface ccd_dec_if;
   import ccd_pkg::*;
   ccd_op_type op;
   logic [4:0] rd;
   logic [4:0] rs1;
   logic [4:0] rs2;
   logic [31:0] imm;
   logic       link;
   logic       bnez;
   modport dec (output op, rd, rs1, rs2, imm, link, bnez);
   modport exe (input op, rd, rs1, rs2, imm, link, bnez);
endinterface
`default_nettype wire

// *** hdl/ccd_decoder.sv ***
`default_nettype none
`include "ccd_defs.svh"
module ccd_decoder
   import ccd_pkg::*;
(
   // instruction and configuration
   input  wire logic [15:0] insn,
   input  wire logic        cap_mode,
   input  wire logic        debug_mode,
   input  wire logic        has_purecap,
   input  wire logic        has_modesw,
   input  wire logic        is_rv32,
   // decoded fields
   ccd_dec_if.dec           d
);
   wire [1:0] quad = insn[1:0];
   wire [2:0] f3   = insn[15:13];
   wire [4:0] rfull = insn[11:7];
   wire [4:0] r2full = insn[6:2];
   wire [4:0] rc_hi = {`CCD_CREG_BASE, insn[9:7]};
   wire [4:0] rc_lo = {`CCD_CREG_BASE, insn[4:2]};
   wire [31:0] imm_b = {{24{insn[12]}}, insn[6:5], insn[2], insn[11:10], insn[4:3], 1'b0};
   wire [31:0] imm_j = {{21{insn[12]}}, insn[8], insn[10:9], insn[6], insn[7], insn[2],
                        insn[11], insn[5:3], 1'b0};
   wire [31:0] imm_16 = {{23{insn[12]}}, insn[4:3], insn[5], insn[2], insn[6], 4'h0};
   wire [31:0] imm_4 = {22'h0, insn[10:7], insn[12:11], insn[5], insn[6], 2'h0};
   wire cap_ok = !cap_mode || has_purecap;
   wire is_msw = (insn == `CCD_MODESW) && has_modesw;
   wire is_br  = quad == `CCD_Q1 && (f3 == `CCD_F3_BEQZ || f3 == `CCD_F3_BNEZ);
   wire is_jal = quad == `CCD_Q1 && f3 == `CCD_F3_JAL && is_rv32;
   wire is_j   = quad == `CCD_Q1 && f3 == `CCD_F3_J;
   wire is_a16 = quad == `CCD_Q1 && f3 == `CCD_F3_LUI16 && rfull == `CCD_REG_SP
                 && imm_16 != 32'h0;
   wire is_d4  = quad == `CCD_Q0 && f3 == `CCD_F3_ADDI4 && imm_4 != 32'h0;
   wire is_q2r = quad == `CCD_Q2 && f3 == `CCD_F3_MVJR && rfull != `CCD_REG_ZERO;
   // bit 12 set with a non-zero source is the register add, not a move
   wire is_mv  = is_q2r && r2full != `CCD_REG_ZERO && !insn[12];
   wire is_jr  = is_q2r && r2full == `CCD_REG_ZERO;
   wire is_flow = is_br || is_jal || is_j || is_jr || is_msw;
   always_comb begin
      d.op   = CCD_OP_NONE;
      d.rd   = `CCD_REG_ZERO;
      d.rs1  = `CCD_REG_ZERO;
      d.rs2  = `CCD_REG_ZERO;
      d.imm  = 32'h0;
      d.link = 1'b0;
      d.bnez = f3[0];
      if (!cap_ok) begin
         d.op = CCD_OP_NONE;
      end else if (debug_mode && is_flow) begin
         d.op = CCD_OP_ILL;
      end else if (is_msw) begin
         d.op = CCD_OP_MODESW;
      end else if (is_br) begin
         d.op  = CCD_OP_BRANCH;
         d.rs1 = rc_hi;
         d.imm = imm_b;
      end else if (is_mv) begin
         d.op  = CCD_OP_MOVE;
         d.rd  = rfull;
         d.rs2 = r2full;
      end else if (is_a16) begin
         d.op  = CCD_OP_ADJ16;
         d.rd  = `CCD_REG_SP;
         d.rs1 = `CCD_REG_SP;
         d.imm = imm_16;
      end else if (is_d4) begin
         d.op  = CCD_OP_DER4;
         d.rd  = rc_lo;
         d.rs1 = `CCD_REG_SP;
         d.imm = imm_4;
      end else if (is_jr) begin
         d.op   = CCD_OP_JREG;
         d.rs1  = rfull;
         d.link = insn[12];
         d.rd   = insn[12] ? `CCD_REG_RA : `CCD_REG_ZERO;
      end else if (is_jal || is_j) begin
         d.op   = CCD_OP_JIMM;
         d.imm  = imm_j;
         d.link = is_jal;
         d.rd   = is_jal ? `CCD_REG_RA : `CCD_REG_ZERO;
      end
   end
endmodule
`default_nettype wire

// *** hdl/ccd_defs.svh ***
`ifndef CCD_DEFS_SVH
`define CCD_DEFS_SVH
// quadrant codes
`define CCD_Q0        2'h0
`define CCD_Q1        2'h1
`define CCD_Q2        2'h2
// funct3 codes
`define CCD_F3_ADDI4  3'h0
`define CCD_F3_JAL    3'h1
`define CCD_F3_LUI16  3'h3
`define CCD_F3_J      3'h5
`define CCD_F3_BEQZ   3'h6
`define CCD_F3_BNEZ   3'h7
`define CCD_F3_MVJR   3'h4
// stack pointer register and link register numbers
`define CCD_REG_SP    5'h02
`define CCD_REG_RA    5'h01
`define CCD_REG_ZERO  5'h00
// compact register base (x8)
`define CCD_CREG_BASE 2'h1
// mode switch full encoding
`define CCD_MODESW    16'h9B0D
// minimum instruction length in bytes
`define CCD_MIN_ILEN  2
// trap cause codes
`define CCD_CAUSE_NONE    4'h0
`define CCD_CAUSE_LENGTH  4'h1
`define CCD_CAUSE_ILLEGAL 4'h2
`endif

// *** hdl/ccd_exec.sv ***
`default_nettype none
`include "ccd_defs.svh"
// Overview of operation
// - taken branch outside pcc bounds faults length
// - flow ops illegal while in debug mode
// - cap move copies whole capability with tag
// - legacy move is add to zero register
// - stack adjust: signed imm times sixteen
// - clear tag if unrepresentable or sealed
// - stack derive: unsigned imm times four
// - legacy stack ops are plain address adds
// - mode toggle flips mode, no exception
// - cap linking jump writes sealed next pcc
// - cap reg jump copies and unseals metadata
// - jump target must fit pcc bounds, except cap reg jump (not checked)
// - legacy linked jumps follow base definitions
// - plain reg jump links to register zero
// - immediate jump same in both modes
// - linked immediate jump only on rv32
// - cap meanings need pure-capability extension
// - mode toggle needs mode-switch extension
// - compact branches compare against register zero
module ccd_exec
   import ccd_pkg::*;
#(
   parameter int XLEN = 32,
   parameter int MW   = 32
)(
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            rst_n,
   // configuration
   input  wire logic            has_purecap,
   input  wire logic            has_modesw,
   input  wire logic            is_rv32,
   input  wire logic            debug_mode,
   // instruction issue
   input  wire logic            insn_valid,
   input  wire logic [15:0]     insn,
   input  wire logic [XLEN-1:0] pc,
   // pcc bounds and state
   input  wire logic [XLEN-1:0] pcc_base,
   input  wire logic [XLEN-1:0] pcc_top,
   input  wire logic [MW-1:0]   pcc_meta,
   // register operands
   input  wire logic [XLEN-1:0] src1_addr,
   input  wire logic [MW-1:0]   src1_meta,
   input  wire logic            src1_tag,
   input  wire logic            src1_sealed,
   input  wire logic            src1_repr,
   input  wire logic [XLEN-1:0] src2_addr,
   input  wire logic [MW-1:0]   src2_meta,
   input  wire logic            src2_tag,
   // register operand selects
   output logic [4:0]           src1_sel_q,
   output logic [4:0]           src2_sel_q,
   // writeback
   output logic                 wb_en_q,
   output logic [4:0]           wb_reg_q,
   output logic [XLEN-1:0]      wb_addr_q,
   output logic [MW-1:0]        wb_meta_q,
   output logic                 wb_tag_q,
   // control flow
   output logic                 redirect_q,
   output logic [XLEN-1:0]      next_pc_q,
   output logic                 pcc_meta_we_q,
   output logic [MW-1:0]        pcc_meta_q,
   // traps and mode
   output logic                 trap_q,
   output logic [3:0]           trap_cause_q,
   output logic                 cap_mode_q,
   output logic                 done_q
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   ccd_dec_if dif ();
   ccd_decoder u_dec (
      .insn        (insn),
      .cap_mode    (cap_mode_q),
      .debug_mode  (debug_mode),
      .has_purecap (has_purecap),
      .has_modesw  (has_modesw),
      .is_rv32     (is_rv32),
      .d           (dif.dec)
   );

   // ----------------------------------------------------------------
   // pipeline: stage one registers selects, stage two executes
   // ----------------------------------------------------------------
   // operands arrive one cycle after select, so decoded fields are held
   ccd_op_type      op_q;
   logic [4:0]      rd_q;
   logic [31:0]     imm_q;
   logic            link_q;
   logic            bnez_q;
   logic            v_q;
   logic [XLEN-1:0] pc_q;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         v_q        <= 1'b0;
         op_q       <= CCD_OP_NONE;
         rd_q       <= 5'h00;
         imm_q      <= 32'h0;
         link_q     <= 1'b0;
         bnez_q     <= 1'b0;
         pc_q       <= '0;
         src1_sel_q <= 5'h00;
         src2_sel_q <= 5'h00;
      end else begin
         v_q        <= insn_valid && !(op_q == CCD_OP_MODESW && v_q);
         op_q       <= dif.op;
         rd_q       <= dif.rd;
         imm_q      <= dif.imm;
         link_q     <= dif.link;
         bnez_q     <= dif.bnez;
         pc_q       <= pc;
         src1_sel_q <= dif.rs1;
         src2_sel_q <= dif.rs2;
      end
   end

   // ----------------------------------------------------------------
   // execute datapath
   // ----------------------------------------------------------------
   wire [XLEN-1:0] imm_x    = imm_q[XLEN-1:0];
   wire [XLEN-1:0] seq_pc   = pc_q + XLEN'(`CCD_MIN_ILEN);
   wire [XLEN-1:0] br_tgt   = pc_q + imm_x;
   wire [XLEN-1:0] jr_tgt   = src1_addr + imm_x;
   wire [XLEN-1:0] jr_tgt_l = {jr_tgt[XLEN-1:1], 1'b0};
   wire [XLEN-1:0] sp_sum   = src1_addr + imm_x;
   wire            br_take  = bnez_q ? (src1_addr != '0) : (src1_addr == '0);
   wire            is_jreg  = op_q == CCD_OP_JREG;
   wire            is_jimm  = op_q == CCD_OP_JIMM;
   wire            is_br    = op_q == CCD_OP_BRANCH;
   wire [XLEN-1:0] tgt      = is_jreg ? (cap_mode_q ? jr_tgt : jr_tgt_l) : br_tgt;
   // a jump through a capability skips the bounds check; bounds always come from pcc
   wire            use_src  = is_jreg && cap_mode_q;
   wire [XLEN-1:0] bnd_top  = pcc_top;
   wire [XLEN-1:0] bnd_base = pcc_base;
   // target plus minimum length must not pass top; overflow counts as out
   wire [XLEN:0]   tgt_end  = {1'b0, tgt} + (XLEN+1)'(`CCD_MIN_ILEN);
   wire            in_bnd   = tgt >= bnd_base && tgt_end <= {1'b0, bnd_top};
   wire            flow     = (is_br && br_take) || is_jreg || is_jimm;
   wire            len_flt  = v_q && flow && !use_src && !in_bnd;
   wire            ill      = v_q && op_q == CCD_OP_ILL;
   wire            cap_st   = cap_mode_q && (op_q == CCD_OP_ADJ16 || op_q == CCD_OP_DER4);
   wire            st_tag   = src1_tag && !src1_sealed && src1_repr;
   wire            do_wb    = v_q && !len_flt && (op_q == CCD_OP_MOVE || op_q == CCD_OP_ADJ16
                              || op_q == CCD_OP_DER4 || ((is_jreg || is_jimm) && link_q));
   wire [MW-1:0]   meta_seal = pcc_meta | MW'(1); // sealed sentry marker in bit 0
   wire [MW-1:0]   meta_uns  = src1_meta & ~MW'(1);

   // ----------------------------------------------------------------
   // writeback and flow outputs
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wb_en_q       <= 1'b0;
         wb_reg_q      <= 5'h00;
         wb_addr_q     <= '0;
         wb_meta_q     <= '0;
         wb_tag_q      <= 1'b0;
         redirect_q    <= 1'b0;
         next_pc_q     <= '0;
         pcc_meta_we_q <= 1'b0;
         pcc_meta_q    <= '0;
         trap_q        <= 1'b0;
         trap_cause_q  <= `CCD_CAUSE_NONE;
         done_q        <= 1'b0;
      end else begin
         wb_en_q       <= do_wb;
         wb_reg_q      <= rd_q;
         redirect_q    <= v_q && flow && !len_flt;
         next_pc_q     <= tgt;
         pcc_meta_we_q <= v_q && use_src;
         pcc_meta_q    <= meta_uns;
         trap_q        <= len_flt || ill;
         trap_cause_q  <= len_flt ? `CCD_CAUSE_LENGTH : ill ? `CCD_CAUSE_ILLEGAL
                          : `CCD_CAUSE_NONE;
         done_q        <= v_q;
         unique case (op_q)
            CCD_OP_MOVE: begin
               wb_addr_q <= src2_addr;
               wb_meta_q <= cap_mode_q ? src2_meta : '0;
               wb_tag_q  <= cap_mode_q && src2_tag;
            end
            CCD_OP_ADJ16, CCD_OP_DER4: begin
               wb_addr_q <= sp_sum;
               wb_meta_q <= cap_mode_q ? src1_meta : '0;
               wb_tag_q  <= cap_st && st_tag;
            end
            CCD_OP_JREG, CCD_OP_JIMM: begin
               wb_addr_q <= seq_pc;
               wb_meta_q <= cap_mode_q ? meta_seal : '0;
               wb_tag_q  <= cap_mode_q;
            end
            default: begin
               wb_addr_q <= '0;
               wb_meta_q <= '0;
               wb_tag_q  <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // execution mode
   // ----------------------------------------------------------------
   // capability mode after reset; toggle has no fault path
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cap_mode_q <= 1'b1;
      end else if (v_q && op_q == CCD_OP_MODESW) begin
         cap_mode_q <= !cap_mode_q;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_toggle;
      v_q && op_q == CCD_OP_MODESW;
   endsequence
   mode_toggle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_toggle |=> cap_mode_q != $past(cap_mode_q) && !trap_q)
      else $error("mode toggle failed");
   len_fault_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      len_flt |=> trap_q && trap_cause_q == `CCD_CAUSE_LENGTH && !redirect_q)
      else $error("length fault not raised");
   branch_fault_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_br && br_take && !in_bnd) |=> trap_q)
      else $error("branch bounds fault missing");
   debug_ill_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_ILL) |=> trap_cause_q == `CCD_CAUSE_ILLEGAL)
      else $error("debug illegal missing");
   cap_move_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_MOVE && cap_mode_q) |=> wb_en_q && wb_tag_q == $past(src2_tag)
      && wb_meta_q == $past(src2_meta))
      else $error("cap move wrong");
   leg_move_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_MOVE && !cap_mode_q) |=> !wb_tag_q && wb_addr_q == $past(src2_addr))
      else $error("legacy move wrong");
   stack_tag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && cap_st && (src1_sealed || !src1_repr)) |=> !wb_tag_q)
      else $error("stack tag not cleared");
   stack_sum_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_ADJ16) |=> wb_reg_q == `CCD_REG_SP
      && wb_addr_q == $past(src1_addr) + $past(imm_x))
      else $error("stack adjust wrong");
   link_seal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (do_wb && cap_mode_q && (is_jreg || is_jimm)) |=> wb_meta_q[0] && wb_tag_q
      && wb_addr_q == $past(pc_q) + XLEN'(`CCD_MIN_ILEN))
      else $error("link not sealed");

   // ----------------------------------------------------------------
   // operand, gating and flow checks
   // ----------------------------------------------------------------
   sequence s_jump;
      v_q && (is_jreg || is_jimm);
   endsequence

   adj16_imm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_ADJ16) |-> imm_x[3:0] == 4'h0 && imm_x != '0
      && (imm_x[XLEN-1:9] == '0 || imm_x[XLEN-1:9] == '1))
      else $error("stack adjust offset out of range");

   adj16_regs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_ADJ16) |-> src1_sel_q == `CCD_REG_SP && rd_q == `CCD_REG_SP)
      else $error("stack adjust register wrong");

   der4_imm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_DER4) |-> imm_x[1:0] == 2'h0 && imm_x != '0
      && imm_x[XLEN-1:10] == '0)
      else $error("stack derive offset wrong");

   der4_regs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_DER4) |-> src1_sel_q == `CCD_REG_SP
      && rd_q[4:3] == `CCD_CREG_BASE)
      else $error("stack derive register wrong");

   leg_stack_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && !cap_mode_q && (op_q == CCD_OP_ADJ16 || op_q == CCD_OP_DER4))
      |=> wb_en_q && !wb_tag_q && wb_meta_q == '0)
      else $error("legacy stack op not plain");

   move_regs_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_MOVE) |-> src2_sel_q != `CCD_REG_ZERO && rd_q != `CCD_REG_ZERO)
      else $error("move register wrong");

   leg_link_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_jump ##0 (link_q && !cap_mode_q && !len_flt) |=> wb_en_q && !wb_tag_q
      && wb_reg_q == `CCD_REG_RA && wb_addr_q == $past(pc_q) + XLEN'(`CCD_MIN_ILEN))
      else $error("legacy link wrong");

   leg_jr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_jreg && !cap_mode_q) |=> !next_pc_q[0])
      else $error("legacy register jump target odd");

   no_link_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_jump ##0 !link_q |=> !wb_en_q)
      else $error("plain jump wrote a link");

   unseal_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_jreg && cap_mode_q) |=> pcc_meta_we_q && !pcc_meta_q[0]
      && pcc_meta_q[MW-1:1] == $past(src1_meta[MW-1:1]) && next_pc_q == $past(src1_addr))
      else $error("register jump metadata wrong");

   meta_we_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(v_q && is_jreg && cap_mode_q) |=> !pcc_meta_we_q)
      else $error("stray metadata write");

   jimm_tgt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_jimm && !len_flt) |=> redirect_q && next_pc_q == $past(pc_q) + $past(imm_x))
      else $error("immediate jump target wrong");

   jump_ok_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && (is_jimm || (is_jreg && !cap_mode_q)) && in_bnd) |=> redirect_q && !trap_q)
      else $error("in-bounds jump faulted");

   br_skip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_br && bnez_q == (src1_addr == '0)) |=> !redirect_q && !trap_q)
      else $error("untaken branch redirected");

   br_take_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_br && bnez_q != (src1_addr == '0) && in_bnd)
      |=> redirect_q && next_pc_q == $past(pc_q) + $past(imm_x))
      else $error("taken branch target wrong");

   br_src_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_br) |-> src1_sel_q[4:3] == `CCD_CREG_BASE)
      else $error("branch source not compact");

   pure_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && cap_mode_q && !$past(has_purecap)) |-> op_q == CCD_OP_NONE)
      else $error("cap meaning without extension");

   msw_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && !$past(has_modesw)) |-> op_q != CCD_OP_MODESW)
      else $error("toggle without extension");

   jal_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && is_jimm && link_q) |-> $past(is_rv32))
      else $error("linked immediate jump off rv32");

   mode_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rst_n && !(v_q && op_q == CCD_OP_MODESW)) |=> cap_mode_q == $past(cap_mode_q))
      else $error("mode changed without toggle");

   ill_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (v_q && op_q == CCD_OP_ILL) |=> !redirect_q && !wb_en_q && !pcc_meta_we_q)
      else $error("illegal op had effects");

endmodule
`default_nettype wire

// *** hdl/ccd_pkg.sv ***
`default_nettype none
package ccd_pkg;
   typedef enum logic [3:0] {
      CCD_OP_NONE   = 4'h0,
      CCD_OP_BRANCH = 4'h1,
      CCD_OP_MOVE   = 4'h2,
      CCD_OP_ADJ16  = 4'h3,
      CCD_OP_DER4   = 4'h4,
      CCD_OP_MODESW = 4'h5,
      CCD_OP_JREG   = 4'h6,
      CCD_OP_JIMM   = 4'h7,
      CCD_OP_ILL    = 4'h8
   } ccd_op_type;
endpackage
`default_nettype wire

// *** verification/ccd_opnd_model.sv ***
`default_nettype none
// ---------------------------------------------
// operand read port of the register file
// ---------------------------------------------
module ccd_opnd_model (
   // register selects from the block
   input  wire logic [4:0]  sel1,
   input  wire logic [4:0]  sel2,
   // state of the first operand, set by the bench
   input  wire logic        sealed,
   input  wire logic        repr,
   // operand values
   output logic      [31:0] a1,
   output logic      [31:0] m1,
   output logic             t1,
   output logic             s1,
   output logic             r1,
   output logic      [31:0] a2,
   output logic      [31:0] m2,
   output logic             t2
);
   timeunit 1ns;
   timeprecision 1ps;
   // every register holds a distinct address so a wrong select shows
   assign a1 = 32'h0000_1000 + ({27'h0000000, sel1} << 6);
   assign a2 = 32'h0000_1000 + ({27'h0000000, sel2} << 6);
   // meta bit0 mirrors the seal state
   assign m1 = {sel1, 26'h0000000, sealed};
   assign m2 = {sel2, 26'h0000000, sealed};
   assign t1 = 1'b1;
   assign t2 = 1'b1;
   assign s1 = sealed;
   assign r1 = repr;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic        core_clk, rst_n, has_purecap, has_modesw, is_rv32, debug_mode;
   logic        insn_valid, sealed, repr, got;
   logic [15:0] insn;
   logic [31:0] pc, pcc_base, pcc_top, pcc_meta, a1, m1, a2, m2;
   logic [31:0] wb_addr_q, wb_meta_q, next_pc_q, pcc_meta_q;
   logic        t1, s1, r1, t2, wb_en_q, wb_tag_q, redirect_q, pcc_meta_we_q;
   logic        trap_q, cap_mode_q, done_q;
   logic [4:0]  src1_sel_q, src2_sel_q, wb_reg_q;
   logic [3:0]  trap_cause_q;
   int          errors, checks_done;
   localparam logic [31:0] PC0 = 32'h0000_0100;
   localparam logic [31:0] PCH = 32'h0000_1FF8;

   ccd_exec #(.XLEN(32), .MW(32)) u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .has_purecap(has_purecap),
      .has_modesw(has_modesw), .is_rv32(is_rv32), .debug_mode(debug_mode),
      .insn_valid(insn_valid), .insn(insn), .pc(pc), .pcc_base(pcc_base),
      .pcc_top(pcc_top), .pcc_meta(pcc_meta), .src1_addr(a1), .src1_meta(m1),
      .src1_tag(t1), .src1_sealed(s1), .src1_repr(r1), .src2_addr(a2),
      .src2_meta(m2), .src2_tag(t2), .src1_sel_q(src1_sel_q),
      .src2_sel_q(src2_sel_q), .wb_en_q(wb_en_q), .wb_reg_q(wb_reg_q),
      .wb_addr_q(wb_addr_q), .wb_meta_q(wb_meta_q), .wb_tag_q(wb_tag_q),
      .redirect_q(redirect_q), .next_pc_q(next_pc_q),
      .pcc_meta_we_q(pcc_meta_we_q), .pcc_meta_q(pcc_meta_q), .trap_q(trap_q),
      .trap_cause_q(trap_cause_q), .cap_mode_q(cap_mode_q), .done_q(done_q));

   ccd_opnd_model u_opnd (
      .sel1(src1_sel_q), .sel2(src2_sel_q), .sealed(sealed), .repr(repr),
      .a1(a1), .m1(m1), .t1(t1), .s1(s1), .r1(r1), .a2(a2), .m2(m2), .t2(t2));

   always #5 core_clk = ~core_clk;

   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   function automatic logic [31:0] addr_of(input logic [4:0] s);
      return 32'h0000_1000 + {21'h000000, s, 6'h00};
   endfunction

   task automatic print_verdict();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // issue one insn, then wait for its completion pulse
   task automatic run(input logic [15:0] i, input logic [31:0] p);
      int n;
      @(posedge core_clk);
      insn_valid <= 1'b1;
      insn       <= i;
      pc         <= p;
      @(posedge core_clk);
      insn_valid <= 1'b0;
      got = 1'b0;
      n = 0;
      while (n < 6 && !got) begin
         @(posedge core_clk);
         #1;
         if (done_q === 1'b1 || trap_q === 1'b1) got = 1'b1;
         n++;
      end
      if (!got) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
         print_verdict();
      end
   endtask

   task automatic set_op(input logic s, input logic r);
      @(posedge core_clk);
      sealed <= s;
      repr   <= r;
   endtask

   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_move();
      run(16'h852E, PC0);
      chk(wb_en_q, 1'b1);
      chk(wb_reg_q, 5'd10);
      chk(wb_addr_q, addr_of(5'd11));
      chk(wb_meta_q, {5'd11, 27'h0000000});
      chk(wb_tag_q, 1'b1);
      run(16'h952E, PC0);
      chk(wb_en_q, 1'b0);
   endtask

   // mid-run reset from legacy mode must bring capability mode back
   task automatic t_reset();
      run(16'h9B0D, PC0);
      chk(cap_mode_q, 1'b0);
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk(cap_mode_q, 1'b1);
      chk(done_q, 1'b0);
      chk(trap_q, 1'b0);
   endtask

   task automatic t_stack();
      run(16'h6141, PC0);
      chk(wb_reg_q, 5'd2);
      chk(wb_addr_q, 32'h0000_1090);
      chk(wb_tag_q, 1'b1);
      run(16'h7101, PC0);
      chk(wb_addr_q, 32'h0000_0E80);
      set_op(1'b1, 1'b1);
      run(16'h1FE4, PC0);
      chk(wb_reg_q, 5'd9);
      chk(wb_addr_q, 32'h0000_147C);
      chk(wb_tag_q, 1'b0);
      set_op(1'b0, 1'b0);
      run(16'h6141, PC0);
      chk(wb_tag_q, 1'b0);
      set_op(1'b0, 1'b1);
   endtask

   task automatic t_branch();
      run(16'hE401, PCH);
      chk(trap_q, 1'b1);
      chk(trap_cause_q, 4'h1);
      run(16'hC401, PC0);
      chk(redirect_q, 1'b0);
      chk(trap_q, 1'b0);
      run(16'hE401, PC0);
      chk(redirect_q, 1'b1);
      chk(next_pc_q, 32'h0000_0108);
   endtask

   task automatic t_jumps();
      run(16'hA021, PC0);
      chk(next_pc_q, 32'h0000_0108);
      chk(wb_en_q, 1'b0);
      run(16'hA021, PCH);
      chk(trap_cause_q, 4'h1);
      run(16'h2021, PC0);
      chk(wb_reg_q, 5'd1);
      chk(wb_addr_q, 32'h0000_0102);
      chk(wb_meta_q[0], 1'b1);
      set_op(1'b1, 1'b1);
      run(16'h8282, PC0);
      chk(next_pc_q, addr_of(5'd5));
      chk(pcc_meta_we_q, 1'b1);
      chk(pcc_meta_q, {5'd5, 27'h0000000});
      chk(wb_en_q, 1'b0);
      run(16'h9282, PC0);
      chk(wb_reg_q, 5'd1);
      chk(wb_meta_q[0], 1'b1);
      set_op(1'b0, 1'b1);
      debug_mode <= 1'b1;
      run(16'hA021, PC0);
      chk(trap_cause_q, 4'h2);
      debug_mode <= 1'b0;
   endtask

   task automatic t_legacy();
      run(16'h9B0D, PC0);
      chk(cap_mode_q, 1'b0);
      chk(trap_q, 1'b0);
      run(16'h852E, PC0);
      chk(wb_addr_q, addr_of(5'd11));
      chk(pcc_meta_we_q, 1'b0);
      run(16'h6141, PC0);
      chk(wb_addr_q, 32'h0000_1090);
      run(16'h8282, PC0);
      chk(next_pc_q, addr_of(5'd5));
      chk(wb_en_q, 1'b0);
      run(16'h2021, PC0);
      chk(wb_addr_q, 32'h0000_0102);
      chk(next_pc_q, 32'h0000_0108);
      run(16'h9B0D, PC0);
      chk(cap_mode_q, 1'b1);
   endtask

   task automatic t_config();
      has_modesw <= 1'b0;
      run(16'h9B0D, PC0);
      chk(cap_mode_q, 1'b1);
      has_modesw  <= 1'b1;
      has_purecap <= 1'b0;
      run(16'h852E, PC0);
      chk(wb_en_q, 1'b0);
      has_purecap <= 1'b1;
      is_rv32     <= 1'b0;
      run(16'h2021, PC0);
      chk(redirect_q, 1'b0);
      is_rv32 <= 1'b1;
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      core_clk    = 1'b0;
      rst_n       = 1'b0;
      has_purecap = 1'b1;
      has_modesw  = 1'b1;
      is_rv32     = 1'b1;
      debug_mode  = 1'b0;
      insn_valid  = 1'b0;
      insn        = 16'h0000;
      pc          = PC0;
      pcc_base    = 32'h0000_0000;
      pcc_top     = 32'h0000_2000;
      pcc_meta    = 32'h0000_0000;
      sealed      = 1'b0;
      repr        = 1'b1;
      errors      = 0;
      checks_done = 0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk(cap_mode_q, 1'b1);
      t_move();
      t_stack();
      t_branch();
      t_jumps();
      t_legacy();
      t_reset();
      t_config();
      print_verdict();
   end
endmodule
`default_nettype wire
